// File: core/ibaf_regs.vh
// constants for the init block fetch and receive address filter
// assumes a 16-bit host memory read port and an APB register slave
// Behaviour
// - block is read as twelve consecutive 16-bit words from offset +00
// - ring length code is bits 15..13 of the ring upper word
// - length code n selects two to the n descriptor entries, 1 to 128
// - ring base is 24 bits: lower word, then upper word low byte
// - first wire bit 1 means logical, 0 means physical compared with node
// - logical address CRC top 6 bits index the 64-bit hash mask
// - hash mask is four words, +08 low through +0E high
// - all-zero mask without promiscuous rejects logical except broadcast
// - broadcast skips the mask, accepted unless disabled and not promiscuous
// - node address bit 0 goes first on wire and must be zero
// - address byte k maps LSB first onto node address bits 8k+7..8k
// - mode word at +00 is copied into the mode control register
// - ring length registers accept writes only after initialization
`ifndef IBAF_REGS_VH
`define IBAF_REGS_VH

// apb byte addresses
`define IBAF_A_CTRL      8'h00
`define IBAF_A_STATUS    8'h04
`define IBAF_A_IBASE     8'h08
`define IBAF_A_MODE      8'h0C
`define IBAF_A_NODE_LO   8'h10
`define IBAF_A_NODE_HI   8'h14
`define IBAF_A_HASH_LO   8'h18
`define IBAF_A_HASH_HI   8'h1C
`define IBAF_A_RX_BASE   8'h20
`define IBAF_A_TX_BASE   8'h24
`define IBAF_A_RX_LEN    8'h28
`define IBAF_A_TX_LEN    8'h2C
`define IBAF_A_LENCODES  8'h30

// init block word indices (byte offset / 2)
`define IBAF_W_MODE      4'h0
`define IBAF_W_NODE0     4'h1
`define IBAF_W_NODE1     4'h2
`define IBAF_W_NODE2     4'h3
`define IBAF_W_HASH0     4'h4
`define IBAF_W_HASH1     4'h5
`define IBAF_W_HASH2     4'h6
`define IBAF_W_HASH3     4'h7
`define IBAF_W_RXLO      4'h8
`define IBAF_W_RXHI      4'h9
`define IBAF_W_TXLO      4'hA
`define IBAF_W_TXHI      4'hB
`define IBAF_W_LAST      4'hB

// fields
`define IBAF_LEN_MSB     15
`define IBAF_LEN_LSB     13
`define IBAF_HIBASE_MSB  7
`define IBAF_MODE_PROM   15
`define IBAF_MODE_DISBC  14
`define IBAF_MODE_DXFCS  3
`define IBAF_CTRL_START  0
`define IBAF_ST_DONE     0
`define IBAF_ST_BUSY     1
`define IBAF_TX_CODE_LSB 4

// crc
`define IBAF_CRC_INIT    32'hFFFFFFFF
`define IBAF_CRC_POLY    32'h04C11DB7
`define IBAF_BCAST       48'hFFFFFFFFFFFF

`endif

// File: core/ibaf_top.v
// init block fetch, ring parameters and receive destination filter
// assumes a host memory port that answers each 16-bit read with memAck
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ibaf_regs.vh"

module ibaf_top (
  // clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // host memory read master
  output reg         memReq,
  output reg  [23:0] memAddr,
  input  wire        memAck,
  input  wire [15:0] memRdData,
  // receive destination filter
  input  wire        rxDestValid,
  input  wire [47:0] rxDestAddr,
  input  wire        rxFrameEnd,
  output reg         rxAccept,
  output reg         rxReject,
  output reg         rxStoreEn,
  // mode outputs
  output reg         txChecksumDisable
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_REQ  = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  // crc over 48 address bits, wire order is bit 0 first
  function [5:0] hashIndex;
    input [47:0] addr;
    reg   [31:0] crc;
    reg          fb;
    integer      i;
    begin
      crc = `IBAF_CRC_INIT;
      for (i = 0; i < 48; i = i + 1) begin
        fb  = crc[31] ^ addr[i];
        crc = {crc[30:0], 1'b0} ^ (fb ? `IBAF_CRC_POLY : 32'h00000000);
      end
      hashIndex = crc[31:26];
    end
  endfunction

  // length code to entry count
  function [15:0] lenDecode;
    input [2:0] code;
    begin
      lenDecode = 16'h0001 << code;
    end
  endfunction

  reg  [1:0]  state_q;
  reg  [3:0]  wordIdx_q;
  reg         initDone_q;
  reg  [23:0] initBase_q;
  reg  [15:0] mode_q;
  reg  [47:0] nodeAddr_q;
  reg  [63:0] hashMask_q;
  reg  [23:0] rxBase_q;
  reg  [23:0] txBase_q;
  reg  [2:0]  rxCode_q;
  reg  [2:0]  txCode_q;
  reg  [15:0] rxRingLen_q;
  reg  [15:0] txRingLen_q;

  wire apbAccess = psel & penable;
  wire apbDone   = apbAccess & pready;
  wire apbWrite  = apbDone & pwrite;
  wire startReq  = apbWrite & (paddr == `IBAF_A_CTRL) & pwdata[`IBAF_CTRL_START];
  wire busy      = (state_q != ST_IDLE);
  wire fetchAck  = (state_q == ST_WAIT) & memAck;
  wire lastWord  = (wordIdx_q == `IBAF_W_LAST);

  // apb timing: one wait cycle, answer registered
  always @(posedge core_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAccess & ~pready;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      if (apbAccess & ~pready) begin
        case (paddr)
          `IBAF_A_CTRL:     prdata <= 32'h00000000;
          `IBAF_A_STATUS:   prdata <= {30'h00000000, busy, initDone_q};
          `IBAF_A_IBASE:    prdata <= {8'h00, initBase_q};
          `IBAF_A_MODE:     prdata <= {16'h0000, mode_q};
          `IBAF_A_NODE_LO:  prdata <= nodeAddr_q[31:0];
          `IBAF_A_NODE_HI:  prdata <= {16'h0000, nodeAddr_q[47:32]};
          `IBAF_A_HASH_LO:  prdata <= hashMask_q[31:0];
          `IBAF_A_HASH_HI:  prdata <= hashMask_q[63:32];
          `IBAF_A_RX_BASE:  prdata <= {8'h00, rxBase_q};
          `IBAF_A_TX_BASE:  prdata <= {8'h00, txBase_q};
          `IBAF_A_RX_LEN:   prdata <= {16'h0000, rxRingLen_q};
          `IBAF_A_TX_LEN:   prdata <= {16'h0000, txRingLen_q};
          `IBAF_A_LENCODES: prdata <= {25'h0000000, txCode_q, 1'b0, rxCode_q};
          default:          pslverr <= 1'b1;
        endcase
      end
    end
  end

  // base of the init block; bit 0 dropped, block is word aligned
  always @(posedge core_clk) begin
    if (!nrst) begin
      initBase_q <= 24'h000000;
    end else if (apbWrite & (paddr == `IBAF_A_IBASE) & ~busy) begin
      initBase_q <= {pwdata[23:1], 1'b0};
    end
  end

  // fetch sequencer
  always @(posedge core_clk) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      wordIdx_q  <= 4'h0;
      initDone_q <= 1'b0;
      memReq     <= 1'b0;
      memAddr    <= 24'h000000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (startReq) begin
            initDone_q <= 1'b0;
            wordIdx_q  <= 4'h0;
            state_q    <= ST_REQ;
          end
        end
        ST_REQ: begin
          memReq  <= 1'b1;
          memAddr <= initBase_q + {19'h00000, wordIdx_q, 1'b0};
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (memAck) begin
            memReq <= 1'b0;
            if (lastWord) begin
              initDone_q <= 1'b1;
              state_q    <= ST_IDLE;
            end else begin
              wordIdx_q <= wordIdx_q + 4'h1;
              state_q   <= ST_REQ;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // capture of init block words into the parameter registers
  always @(posedge core_clk) begin
    if (!nrst) begin
      mode_q     <= 16'h0000;
      nodeAddr_q <= 48'h000000000000;
      hashMask_q <= 64'h0000000000000000;
      rxBase_q   <= 24'h000000;
      txBase_q   <= 24'h000000;
      rxCode_q   <= 3'h0;
      txCode_q   <= 3'h0;
    end else if (fetchAck) begin
      case (wordIdx_q)
        `IBAF_W_MODE:  mode_q              <= memRdData;
        `IBAF_W_NODE0: nodeAddr_q[15:0]    <= memRdData;
        `IBAF_W_NODE1: nodeAddr_q[31:16]   <= memRdData;
        `IBAF_W_NODE2: nodeAddr_q[47:32]   <= memRdData;
        `IBAF_W_HASH0: hashMask_q[15:0]    <= memRdData;
        `IBAF_W_HASH1: hashMask_q[31:16]   <= memRdData;
        `IBAF_W_HASH2: hashMask_q[47:32]   <= memRdData;
        `IBAF_W_HASH3: hashMask_q[63:48]   <= memRdData;
        `IBAF_W_RXLO:  rxBase_q[15:0]      <= memRdData;
        `IBAF_W_RXHI: begin
          rxBase_q[23:16] <= memRdData[`IBAF_HIBASE_MSB:0];
          rxCode_q        <= memRdData[`IBAF_LEN_MSB:`IBAF_LEN_LSB];
        end
        `IBAF_W_TXLO:  txBase_q[15:0]      <= memRdData;
        `IBAF_W_TXHI: begin
          txBase_q[23:16] <= memRdData[`IBAF_HIBASE_MSB:0];
          txCode_q        <= memRdData[`IBAF_LEN_MSB:`IBAF_LEN_LSB];
        end
        default: ;
      endcase
    end
  end

  // ring lengths: from codes at end of init, then software writable
  always @(posedge core_clk) begin
    if (!nrst) begin
      rxRingLen_q <= 16'h0000;
      txRingLen_q <= 16'h0000;
    end else if (fetchAck & lastWord) begin
      rxRingLen_q <= lenDecode(rxCode_q);
      txRingLen_q <= lenDecode(memRdData[`IBAF_LEN_MSB:`IBAF_LEN_LSB]);
    end else if (apbWrite & initDone_q & ~busy) begin
      if (paddr == `IBAF_A_RX_LEN)
        rxRingLen_q <= pwdata[15:0];
      if (paddr == `IBAF_A_TX_LEN)
        txRingLen_q <= pwdata[15:0];
    end
  end

  always @(posedge core_clk) begin
    if (!nrst)
      txChecksumDisable <= 1'b0;
    else
      txChecksumDisable <= mode_q[`IBAF_MODE_DXFCS];
  end

  // destination filter
  wire        prom      = mode_q[`IBAF_MODE_PROM];
  wire        disBcast  = mode_q[`IBAF_MODE_DISBC];
  wire        isLogical = rxDestAddr[0];
  wire        isBcast   = (rxDestAddr == `IBAF_BCAST);
  wire [5:0]  hIdx      = hashIndex(rxDestAddr);
  reg         passD;

  always @* begin
    passD = 1'b0;
    if (prom)
      passD = 1'b1;
    else if (!isLogical)
      passD = (rxDestAddr == nodeAddr_q);
    else if (isBcast)
      passD = ~disBcast;
    else
      passD = hashMask_q[hIdx];
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      rxAccept  <= 1'b0;
      rxReject  <= 1'b0;
      rxStoreEn <= 1'b0;
    end else begin
      rxAccept <= rxDestValid & initDone_q & passD;
      rxReject <= rxDestValid & ~(initDone_q & passD);
      if (rxDestValid & initDone_q & passD)
        rxStoreEn <= 1'b1;
      else if (rxFrameEnd | rxDestValid)
        rxStoreEn <= 1'b0;
    end
  end

endmodule // ibaf_top
`default_nettype wire

// File: sim/ibaf_assertions.sv
// checker for fetch handshake and filter decision
// bound to ibaf_top, sees its ports only
`timescale 1ns/1ns
`default_nettype none
module ibaf_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // memory port
  input wire logic        memReq,
  input wire logic [23:0] memAddr,
  input wire logic        memAck,
  // filter
  input wire logic        rxDestValid,
  input wire logic        rxFrameEnd,
  input wire logic        rxAccept,
  input wire logic        rxReject,
  input wire logic        rxStoreEn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_wait; memReq && !memAck; endsequence
  sequence s_ack; memReq && memAck; endsequence
  property p_reqHold; s_wait |=> memReq && $stable(memAddr); endproperty
  property p_ackDrop; s_ack |=> !memReq; endproperty
  property p_wordAlign; memReq |-> !memAddr[0]; endproperty
  property p_decide; rxDestValid |=> rxAccept ^ rxReject; endproperty
  property p_cause; rxAccept || rxReject |-> $past(rxDestValid); endproperty
  property p_storeOnAccept; $rose(rxStoreEn) |-> rxAccept; endproperty
  property p_rejectNoStore; rxReject |-> !rxStoreEn; endproperty
  property p_endStops; rxFrameEnd && !rxDestValid |=> !rxStoreEn; endproperty
  a_reqHold: assert property (p_reqHold)
    else $error("fetch request not held");
  a_ackDrop: assert property (p_ackDrop)
    else $error("fetch request kept after answer");
  a_wordAlign: assert property (p_wordAlign)
    else $error("fetch address not word aligned");
  a_decide: assert property (p_decide)
    else $error("no single decision after address");
  a_cause: assert property (p_cause)
    else $error("decision without address");
  a_storeOnAccept: assert property (p_storeOnAccept)
    else $error("store enabled without accept");
  a_rejectNoStore: assert property (p_rejectNoStore)
    else $error("store enabled on reject");
  a_endStops: assert property (p_endStops)
    else $error("store kept after frame end");
endmodule // ibaf_checker

bind ibaf_top ibaf_checker u_chk (
  .core_clk(core_clk), .nrst(nrst), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
  .rxDestValid(rxDestValid), .rxFrameEnd(rxFrameEnd), .rxAccept(rxAccept),
  .rxReject(rxReject), .rxStoreEn(rxStoreEn));
`default_nettype wire

// File: sim/ibaf_mem_model.sv
// host memory model holding the init block
// answers a read after waitCycles idle cycles
`timescale 1ns/1ns
`default_nettype none
module ibaf_mem_model (
  // clock and pacing
  input  wire logic        core_clk,
  input  wire logic [3:0]  waitCycles,
  // read port
  input  wire logic        memReq,
  input  wire logic [23:0] memAddr,
  output var  logic        memAck,
  output var  logic [15:0] memRdData
);
  logic [15:0] mem [0:15];
  logic [3:0]  cnt;
  initial begin
    memAck = 1'h0;
    memRdData = 16'h0;
    cnt = 4'h0;
  end
  // released bus toggles so stale data never looks valid
  always @(posedge core_clk) begin
    memAck <= 1'h0;
    memRdData <= ~memRdData;
    cnt <= cnt + 4'h1;
    if (!memReq || memAck) cnt <= 4'h0;
    else if (cnt == waitCycles) begin
      memAck <= 1'h1;
      memRdData <= mem[memAddr[4:1]];
    end
  end
endmodule // ibaf_mem_model
`default_nettype wire

// File: sim/init_block_address_filter_tb_top.sv
// bench for ibaf_top: apb master and filter driver
// host memory comes from ibaf_mem_model
`timescale 1ns/1ns
`default_nettype none
module init_block_address_filter_tb_top;
  localparam logic [47:0] NODE = 48'hA5B4C3D2E1F0;
  localparam logic [47:0] MCA  = 48'h0100005E0001;
  localparam logic [47:0] MCB  = 48'h0000335E0033;
  localparam logic [47:0] BC   = 48'hFFFFFFFFFFFF;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, memReq, memAck;
  logic        rxDestValid, rxFrameEnd, rxAccept, rxReject, rxStoreEn, txCsDis;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] memAddr;
  logic [15:0] memRdData;
  logic [3:0]  waitCycles;
  logic [47:0] rxDestAddr;
  int          fails, samplesChecked;
  ibaf_top u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memRdData(memRdData), .rxDestValid(rxDestValid), .rxDestAddr(rxDestAddr),
    .rxFrameEnd(rxFrameEnd), .rxAccept(rxAccept), .rxReject(rxReject),
    .rxStoreEn(rxStoreEn), .txChecksumDisable(txCsDis));
  ibaf_mem_model u_mem (.core_clk(core_clk), .waitCycles(waitCycles), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .memRdData(memRdData));
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    samplesChecked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = pslverr ? 32'hEEEEEEEE : prdata;
    {psel, penable} <= 2'h0;
  endtask
  function automatic logic [5:0] crcIdx(input logic [47:0] a);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++)
      c = {c[30:0], 1'h0} ^ ((c[31] ^ a[i]) ? 32'h04C11DB7 : 32'h0);
    return c[31:26];
  endfunction
  task automatic t_init(input logic [15:0] m, input logic [63:0] h, input logic [2:0] r, t);
    logic [191:0] b;
    logic [31:0]  e [0:9];
    b = {t, 5'h00, 8'h34, 16'h1358, r, 5'h1F, 8'h12, 16'h2468, h, NODE, m};
    e = '{m, NODE[31:0], NODE[47:32], h[31:0], h[63:32], 32'h122468, 32'h341358,
          32'h1 << r, 32'h1 << t, {t, 1'h0, r}};
    for (int i = 0; i < 12; i++) u_mem.mem[i] = b[16*i +: 16];
    apb(8'h08, 1'h1, 32'h00012340);
    apb(8'h00, 1'h1, 32'h1);
    do apb(8'h04, 1'h0, 32'h0); while (rd[1:0] !== 2'h1);
    for (int i = 0; i < 10; i++) begin
      apb(8'h0C + 8'(4 * i), 1'h0, 32'h0);
      chk("init reg", e[i], rd);
    end
    chk("tx checksum disable", m[3], txCsDis);
  endtask
  // outputs are read at the edge after the one that launched them
  task automatic t_filt(input logic [47:0] a, input logic acc);
    @(posedge core_clk);
    {rxDestValid, rxDestAddr} <= {1'h1, a};
    @(posedge core_clk);
    rxDestValid <= 1'h0;
    rxFrameEnd  <= 1'h1;
    @(posedge core_clk);
    rxFrameEnd <= 1'h0;
    chk("accept reject store", {acc, !acc, acc}, {rxAccept, rxReject, rxStoreEn});
    @(posedge core_clk);
    chk("store after end", 1'h0, rxStoreEn);
  endtask
  task automatic t_pre;
    apb(8'h40, 1'h0, 32'h0);
    chk("unmapped", 32'hEEEEEEEE, rd);
    apb(8'h28, 1'h1, 32'h5);
    apb(8'h28, 1'h0, 32'h0);
    chk("ring length before init", 32'h0, rd);
    t_filt(BC, 1'h0);
  endtask
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      waitCycles <= i[0] ? 4'h3 : 4'h0;
      t_init(16'h0008, 64'h0, i[2:0], 3'h7 - i[2:0]);
    end
    apb(8'h2C, 1'h1, 32'h5);
    apb(8'h2C, 1'h0, 32'h0);
    chk("ring length after init", 32'h5, rd);
  endtask
  task automatic t_hash;
    t_init(16'h0000, 64'h1 << crcIdx(MCA), 3'h3, 3'h2);
    t_filt(NODE, 1'h1);
    t_filt(NODE ^ 48'h010000, 1'h0);
    t_filt(MCA, 1'h1);
    t_filt(MCB, crcIdx(MCB) == crcIdx(MCA));
    t_filt(BC, 1'h1);
  endtask
  task automatic t_bcast;
    t_init(16'h0000, 64'h0, 3'h1, 3'h1);
    t_filt(MCA, 1'h0);
    t_filt(BC, 1'h1);
    t_init(16'h4000, 64'h0, 3'h1, 3'h1);
    t_filt(BC, 1'h0);
    t_init(16'hC000, 64'h0, 3'h1, 3'h1);
    t_filt(BC, 1'h1);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    results();
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, rxDestValid, rxFrameEnd} = '0;
    {rxDestAddr, waitCycles, fails, samplesChecked} = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'h1;
    t_pre();
    t_codes();
    t_hash();
    t_bcast();
    results();
  end
endmodule // init_block_address_filter_tb_top
`default_nettype wire
